// file: logic/pulse_time_tagger.sv
// Module: four-channel pulse time tagger and coincidence counter
// Operation
// - A stop channel sampled high at a sample clock rising edge is an event.
// - After an event the channel is ignored for one sample cycle.
// - Continued high, or high again next cycle, makes no new event.
// - Events reach the tagging logic two sample cycles after capture.
// - A coincidence needs both channels high on the same sample edge.
// - Stamp counter counts sample cycles, zeroed by start event or clear.
// - One start input, four stop inputs and two TTL outputs.
// - Internal clock: one stamp increment per 48 MHz period, 20.83 ns.
// - External clock mode samples and stamps on external clock up to 96 MHz.
// - Each TTL output toggles or pulses on command, independently.
// - A commanded pulse lasts exactly one sample clock cycle, internal or external.
// - Host may read events or statistics at any time during acquisition.
// - Two functions: time stamping, or counts and coincidence statistics.
`timescale 1ns/100ps

module pulse_time_tagger
(
    // Sample clock and reset (internal 48 MHz or external up to 96 MHz)
    input  wire logic                                            ref_clk,
    input  wire logic                                            resetn,
    // Function select, steady while running
    input  wire pulse_time_tagger_pkg::acq_fn_t                  acqFn,
    // Detector pins
    input  wire logic                                            startIn,
    input  wire logic [pulse_time_tagger_pkg::NUM_STOP-1:0]      stopIn,
    // Host commands
    input  wire logic                                            clearCmd,
    input  wire pulse_time_tagger_pkg::ttl_cmd_t                 ttlCmd,
    // Event stream toward the USB bridge
    output logic                                                 eventValid,
    output pulse_time_tagger_pkg::tag_event_t                    eventData,
    // Statistics, readable at any time
    output logic [pulse_time_tagger_pkg::NUM_STOP*pulse_time_tagger_pkg::COUNT_W-1:0] chanCounts,
    output logic [pulse_time_tagger_pkg::NUM_PAIRS*pulse_time_tagger_pkg::COUNT_W-1:0] pairCounts,
    // TTL outputs
    output logic [pulse_time_tagger_pkg::NUM_TTL-1:0]            ttlOut
);

    localparam int NS = pulse_time_tagger_pkg::NUM_STOP;
    localparam int NI = NS + 1;
    localparam int CW = pulse_time_tagger_pkg::COUNT_W;

    // -------------------------------------------------------------------------
    // Input capture
    // -------------------------------------------------------------------------
    logic [NI-1:0] syncA_r;
    logic [NI-1:0] syncB_r;
    logic [NI-1:0] prevB_r;
    logic [NI-1:0] rise;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            syncA_r <= '0;
            syncB_r <= '0;
            prevB_r <= '0;
        end
        else
        begin
            syncA_r <= {startIn, stopIn};
            syncB_r <= syncA_r;
            prevB_r <= syncB_r;
        end
    end

    // high at edge, only after low
    // held high makes no repeat; a high after a high is the same level
    // the cycle after an event cannot re-trigger since prevB is high
    assign rise = syncB_r & ~prevB_r;

    // -------------------------------------------------------------------------
    // Delay to the tagger; two cycles counted from capture into syncA
    // -------------------------------------------------------------------------
    logic [NI-1:0] dly_r [pulse_time_tagger_pkg::PIPE_DEPTH-2];

    // capture(1) + sync(1) + this stage(1) = 3 cycles to tagger
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dly_r[0] <= '0;
        end
        else
        begin
            dly_r[0] <= rise;
        end
    end

    logic [NS-1:0] stopEvt;
    logic          startEvt;
    assign stopEvt  = dly_r[0][NS-1:0];
    assign startEvt = dly_r[0][NS];

    // -------------------------------------------------------------------------
    // Timestamp counter
    // -------------------------------------------------------------------------
    logic [pulse_time_tagger_pkg::STAMP_W-1:0] stamp_r;
    logic [pulse_time_tagger_pkg::STAMP_W-1:0] stamp_nxt;
    logic                                      wrap_r;
    logic                                      wrapHit;

    assign wrapHit   = &stamp_r;
    assign stamp_nxt = stamp_r + 1'b1;

    // zeroed by start event or host clear
    // one increment per sample clock period
    // same logic whichever clock drives ref_clk
    // wrap flag held until next zeroing, zeroing wins
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stamp_r <= pulse_time_tagger_pkg::STAMP_RESET;
            wrap_r  <= 1'b0;
        end
        else if (startEvt || clearCmd)
        begin
            stamp_r <= pulse_time_tagger_pkg::STAMP_RESET;
            wrap_r  <= 1'b0;
        end
        else
        begin
            stamp_r <= stamp_nxt;
            if (wrapHit)
            begin
                wrap_r <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Event output in time-tag function
    // -------------------------------------------------------------------------
    // events only in time-tag function
    // stream offered as it happens, host drains through the bridge
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            eventValid <= 1'b0;
            eventData  <= '0;
        end
        else
        begin
            eventValid <= (|stopEvt) && (acqFn == pulse_time_tagger_pkg::FN_TIMETAG);
            if (|stopEvt)
            begin
                eventData.hits    <= stopEvt;
                eventData.wrapped <= wrap_r | wrapHit;
                eventData.stamp   <= stamp_r;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Statistics in counts function
    // -------------------------------------------------------------------------
    logic countOn;
    assign countOn = (acqFn == pulse_time_tagger_pkg::FN_COUNTS);

    // Maps a pair index to its two channels
    function automatic logic pairHit(input int p, input logic [NS-1:0] ev);
        int a;
        int b;
        a = (p < 3) ? 0 : ((p < 5) ? 1 : 2);
        b = (p < 3) ? p + 1 : ((p < 5) ? p - 1 : 3);
        pairHit = ev[a] & ev[b];
    endfunction : pairHit

    genvar g;
    generate
        for (g = 0; g < NS; g++)
        begin : gChan
            // Per channel count, cleared by host clear only in a cycle with no counted event for it, not by a start event
            always_ff @(posedge ref_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    chanCounts[g*CW +: CW] <= pulse_time_tagger_pkg::COUNT_RESET;
                end
                else if (countOn && stopEvt[g])
                begin
                    chanCounts[g*CW +: CW] <= chanCounts[g*CW +: CW] + 32'h0000_0001;
                end
                else if (clearCmd)
                begin
                    chanCounts[g*CW +: CW] <= pulse_time_tagger_pkg::COUNT_RESET;
                end
            end
        end
        for (g = 0; g < pulse_time_tagger_pkg::NUM_PAIRS; g++)
        begin : gPair
            // both seen on the same edge
            always_ff @(posedge ref_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    pairCounts[g*CW +: CW] <= pulse_time_tagger_pkg::COUNT_RESET;
                end
                else if (countOn && pairHit(g, stopEvt))
                begin
                    pairCounts[g*CW +: CW] <= pairCounts[g*CW +: CW] + 32'h0000_0001;
                end
                else if (clearCmd)
                begin
                    pairCounts[g*CW +: CW] <= pulse_time_tagger_pkg::COUNT_RESET;
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------------
    // TTL outputs
    // -------------------------------------------------------------------------
    logic [pulse_time_tagger_pkg::NUM_TTL-1:0] level_r;

    // pulse lasts one clock, same logic whichever clock drives ref_clk
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            level_r <= '0;
            ttlOut  <= '0;
        end
        else
        begin
            level_r <= level_r ^ ttlCmd.toggle;
            ttlOut  <= (level_r ^ ttlCmd.toggle) ^ ttlCmd.pulse;
        end
    end

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    stamp_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (startEvt || clearCmd) |=> (stamp_r == '0))
        else $error("stamp not zeroed");

    stamp_count_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        !(startEvt || clearCmd) |=> (stamp_r == $past(stamp_r) + 32'h0000_0001))
        else $error("stamp did not advance");

    event_lat_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (syncA_r[0] && !syncB_r[0] && !prevB_r[0]) |-> ##2 stopEvt[0])
        else $error("event latency wrong");

    no_repeat_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        stopEvt[0] |=> !stopEvt[0])
        else $error("retrigger in dead time");

    held_high_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (syncB_r[3] && prevB_r[3]) |=> !stopEvt[3])
        else $error("held level made event");

    tag_out_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (stopEvt != '0 && acqFn == pulse_time_tagger_pkg::FN_TIMETAG)
        |=> eventValid && eventData.hits == $past(stopEvt))
        else $error("event not offered");

    pair_count_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (countOn && stopEvt[0] && stopEvt[1] && !clearCmd)
        |=> pairCounts[31:0] == $past(pairCounts[31:0]) + 32'h0000_0001)
        else $error("coincidence missed");

    ttl_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (ttlCmd.pulse[0] && !ttlCmd.toggle[0]) ##1 (!ttlCmd.pulse[0] && !ttlCmd.toggle[0])
        |=> ttlOut[0] == level_r[0])
        else $error("pulse longer than one cycle");

    wrap_mark_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (wrapHit && !startEvt && !clearCmd) |=> wrap_r && stamp_r == '0)
        else $error("wrap not marked");

endmodule : pulse_time_tagger

// file: logic/pulse_time_tagger_pkg.sv
// Package: constants and carrier types for the four-channel pulse time tagger
package pulse_time_tagger_pkg;

    // -------------------------------------------------------------------------
    // Structure
    // -------------------------------------------------------------------------
    localparam int          NUM_STOP    = 4;
    localparam int          NUM_TTL     = 2;
    localparam int          STAMP_W     = 32;
    localparam int          COUNT_W     = 32;
    localparam int          NUM_PAIRS   = 6;
    localparam int          PIPE_DEPTH  = 3;

    // -------------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------------
    localparam real         INT_CLK_MHZ     = 48.0;
    localparam real         INT_PERIOD_NS   = 20.83;
    localparam real         EXT_CLK_MAX_MHZ = 96.0;
    localparam int          DEAD_CYCLES     = 1;
    localparam int          PULSE_CYCLES    = 1;

    // -------------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------------
    localparam logic [STAMP_W-1:0] STAMP_RESET = 32'h0000_0000;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h0000_0000;

    // Acquisition function
    typedef enum logic [0:0]
    {
        FN_TIMETAG = 1'b0,
        FN_COUNTS  = 1'b1
    } acq_fn_t;

    // One stamped event toward the host side
    typedef struct packed
    {
        logic [NUM_STOP-1:0] hits;
        logic                wrapped;
        logic [STAMP_W-1:0]  stamp;
    } tag_event_t;

    // TTL output command from software
    typedef struct packed
    {
        logic [NUM_TTL-1:0] toggle;
        logic [NUM_TTL-1:0] pulse;
    } ttl_cmd_t;

endpackage : pulse_time_tagger_pkg

// file: tb/host_model.sv
// Host-side model: issues clear and TTL commands, collects stamped events
`timescale 1ns/100ps

module host_model
(
    // Clock and reset
    input  wire logic                               ref_clk,
    input  wire logic                               resetn,
    // Event stream from the tagger
    input  wire logic                               eventValid,
    input  wire pulse_time_tagger_pkg::tag_event_t  eventData,
    // Commands toward the tagger
    output logic                                    clearCmd,
    output pulse_time_tagger_pkg::ttl_cmd_t         ttlCmd
);
    int                                 evCount = 0;
    pulse_time_tagger_pkg::tag_event_t  lastEvent;

    initial
    begin
        clearCmd = 1'b0;
        ttlCmd   = '0;
    end

    // read at any time
    // Falling edge sampling keeps clear of the launch edge
    always @(negedge ref_clk)
    begin
        if (resetn === 1'b1 && eventValid === 1'b1)
        begin
            evCount++;
            lastEvent = eventData;
        end
    end

    // One-cycle command pulse, launched just after an edge
    task send(input logic clr, input logic [3:0] ttl);
        @(posedge ref_clk);
        #1;
        clearCmd = clr;
        ttlCmd   = ttl;
        @(posedge ref_clk);
        #1;
        clearCmd = 1'b0;
        ttlCmd   = '0;
    endtask : send
endmodule : host_model

// file: tb/testbench.sv
// Self-checking testbench for the pulse time tagger
`timescale 1ns/100ps

module testbench;
    logic                                    ref_clk = 1'b0;
    logic                                    resetn  = 1'b0;
    pulse_time_tagger_pkg::acq_fn_t          acqFn   = pulse_time_tagger_pkg::FN_TIMETAG;
    logic                                    startIn = 1'b0;
    logic [pulse_time_tagger_pkg::NUM_STOP-1:0] stopIn = '0;
    logic                                    clearCmd;
    pulse_time_tagger_pkg::ttl_cmd_t         ttlCmd;
    logic                                    eventValid;
    pulse_time_tagger_pkg::tag_event_t       eventData;
    logic [127:0]                            chanCounts;
    logic [191:0]                            pairCounts;
    logic [1:0]                              ttlOut;
    int                                      error_cnt = 0;
    int                                      cmp_count = 0;
    int                                      cycles    = 0;

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    pulse_time_tagger u_pulse_time_tagger (.ref_clk(ref_clk), .resetn(resetn), .acqFn(acqFn),
        .startIn(startIn), .stopIn(stopIn), .clearCmd(clearCmd), .ttlCmd(ttlCmd),
        .eventValid(eventValid), .eventData(eventData), .chanCounts(chanCounts),
        .pairCounts(pairCounts), .ttlOut(ttlOut));

    host_model u_host_model (.ref_clk(ref_clk), .resetn(resetn), .eventValid(eventValid),
        .eventData(eventData), .clearCmd(clearCmd), .ttlCmd(ttlCmd));

    task bad(input string m);
        error_cnt++;
        $display("BAD %0t %s", $time, m);
    endtask : bad

    // Advance n edges, then step off the edge
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task do_reset(input pulse_time_tagger_pkg::acq_fn_t fn);
        resetn = 1'b0;
        acqFn  = fn;
        tick(4);
        resetn = 1'b1;
        tick(1);
    endtask : do_reset

    // Single short pulse: event output three edges after the capturing edge
    task t_latency;
        int at;
        int n0;
        at = -1;
        n0 = u_host_model.evCount;
        stopIn = 4'h2;
        tick(1);
        stopIn = '0;
        for (int k = 1; k <= 6; k++)
        begin
            tick(1);
            if (eventValid === 1'b1) at = k;
        end
        cmp_count += 3;
        if (at != 3) bad("event latency wrong");
        if (u_host_model.lastEvent.hits !== 4'h2) bad("hit mask wrong");
        if (u_host_model.evCount != n0 + 1) bad("host event count wrong");
    endtask : t_latency

    // Held level gives one event; a low gap then high gives a second
    task t_held;
        int n0;
        n0 = u_host_model.evCount;
        stopIn = 4'h8;
        tick(6);
        stopIn = '0;
        tick(1);
        stopIn = 4'h8;
        tick(1);
        stopIn = '0;
        tick(8);
        cmp_count += 2;
        if (u_host_model.evCount != n0 + 2) bad("held input event count wrong");
        if (chanCounts !== '0 || pairCounts !== '0) bad("counts in time-tag function");
    endtask : t_held

    // Stamp after zeroing, then a stop pulse gap cycles later
    task stamp_after(input logic useStart, input int gap, output logic [31:0] s);
        if (useStart)
        begin
            startIn = 1'b1;
            tick(1);
            startIn = 1'b0;
        end
        else
            u_host_model.send(1'b1, 4'h0);
        tick(gap);
        stopIn = 4'h1;
        tick(1);
        stopIn = '0;
        tick(6);
        s = u_host_model.lastEvent.stamp;
    endtask : stamp_after

    task t_stamp;
        logic [31:0] s1;
        logic [31:0] s2;
        for (int u = 0; u < 2; u++)
        begin
            stamp_after(u[0], 2, s1);
            stamp_after(u[0], 7, s2);
            cmp_count += 3;
            if (s2 - s1 !== 32'h0000_0005) bad("stamp spacing wrong");
            if (s1 !== (u[0] ? 32'h0000_0002 : 32'h0000_0005)) bad("stamp not zeroed");
            if (u_host_model.lastEvent.wrapped !== 1'b0) bad("false wrap mark");
        end
    endtask : t_stamp

    // Counts function: coincidence only on a shared edge, no event stream
    task t_counts;
        int n0;
        do_reset(pulse_time_tagger_pkg::FN_COUNTS);
        n0 = u_host_model.evCount;
        stopIn = 4'h3;
        tick(1);
        stopIn = '0;
        tick(1);
        stopIn = 4'h4;
        tick(1);
        stopIn = '0;
        tick(8);
        cmp_count += 5;
        if (chanCounts !== {32'h0, 32'h1, 32'h1, 32'h1}) bad("channel counts wrong");
        if (pairCounts[31:0] !== 32'h1) bad("pair 01 count wrong");
        if (pairCounts[191:32] !== '0) bad("spurious coincidence");
        if (u_host_model.evCount != n0) bad("event in counts function");
        u_host_model.send(1'b1, 4'h0);
        tick(1);
        if (chanCounts !== '0) bad("counts not cleared");
    endtask : t_counts

    // TTL toggle and one-cycle pulses, channels independent
    task t_ttl;
        int hi1;
        int lo0;
        hi1 = 0;
        lo0 = 0;
        cmp_count += 4;
        if (ttlOut !== 2'b00) bad("ttl reset level wrong");
        u_host_model.send(1'b0, 4'h4);
        tick(2);
        if (ttlOut !== 2'b01) bad("toggle failed");
        fork
            u_host_model.send(1'b0, 4'h3);
            for (int k = 0; k < 6; k++)
            begin
                tick(1);
                if (ttlOut[1] === 1'b1) hi1++;
                if (ttlOut[0] === 1'b0) lo0++;
            end
        join
        if (hi1 != 1 || lo0 != 1) bad("pulse width wrong");
        tick(2);
        if (ttlOut !== 2'b01) bad("level lost after pulse");
    endtask : t_ttl

    task report_and_stop;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // Hang guard, far above the roughly 110 cycles the run needs
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial
    begin
        do_reset(pulse_time_tagger_pkg::FN_TIMETAG);
        t_ttl();
        t_latency();
        t_held();
        t_stamp();
        t_counts();
        report_and_stop();
    end
endmodule : testbench
